// ===== scaf_cfg.svh
`ifndef SCAF_CFG_SVH
`define SCAF_CFG_SVH
// Register byte offsets
`define SCAF_OFF_CTRL    4'h0
`define SCAF_OFF_TXDATA  4'h4
`define SCAF_OFF_RXDATA  4'h8
`define SCAF_OFF_STATUS  4'hC
// Control field positions
`define SCAF_CTRL_AUTOPULL 0
`define SCAF_CTRL_AUTOPUSH 1
`define SCAF_CTRL_MRX      2
`define SCAF_CTRL_MTX      3
`define SCAF_CTRL_PULLTH   8
`define SCAF_CTRL_PUSHTH   16
`define SCAF_CTRL_RESTART  31
// Reset values and counts
`define SCAF_CTRL_RESET    32'h0000_0000
`define SCAF_HALF_DEPTH    4
`define SCAF_FULL_COUNT    6'h20
`define SCAF_ISR_RESET     6'h00
`define SCAF_OSR_RESET     6'h20
`endif

// ===== scaf_pkg.sv
package scaf_pkg;
   typedef enum logic [2:0] {
      SCAF_OP_NONE,
      SCAF_OP_OUT,
      SCAF_OP_IN,
      SCAF_OP_PULL,
      SCAF_OP_PUSH,
      SCAF_OP_MOV_OSR,
      SCAF_OP_MOV_ISR,
      SCAF_OP_OUT_ISR
   } scaf_op_t;
   typedef struct packed {
      scaf_op_t    op;
      logic [5:0]  count;
      logic        if_flag;
      logic [31:0] data;
      logic        side_valid;
      logic [4:0]  side_value;
   } scaf_instr_t;
   typedef struct packed {
      logic        rx_full;
      logic        rx_empty;
      logic        tx_full;
      logic        tx_empty;
   } scaf_flags_t;
   typedef struct packed {
      logic        stall;
      logic        out_valid;
      logic [31:0] out_data;
      logic        push_valid;
   } scaf_resp_t;
endpackage

// ===== scaf_core.sv
`timescale 1ns/10ps
`include "scaf_cfg.svh"
// Summary of operation
// - Unmerged: separate four-word transmit and receive queues.
// - Merge setting forms one eight-word queue in chosen direction.
// - Merged toward transmit: receive has no room, push stalls, flags full and empty.
// - Merged toward receive: transmit unavailable, flags full and empty.
// - Both merge bits: both queues unavailable.
// - Changing merge setting discards all queued words.
// - Two independent six-bit saturating shift counters.
// - Reset or restart: input counter zero, output counter thirty-two.
// - Output and input shifts add their bit counts.
// - Refill zeroes output counter; flush zeroes input counter.
// - Move into a shift register clears its counter.
// - Output shift into input register sets input counter to n.
// - Auto-refill on output shift reaching threshold, if a word is present.
// - Auto-flush on input shift reaching threshold pushes and clears register.
// - Thresholds compared every shift; separate enables for refill and flush.
// - Flush at threshold stalls if receive full, else pushes and zeroes.
// - Input shift with flush completes in one cycle unless stalled.
// - Thresholds 1 to 32; zero field means 32.
// - Conditional refill uses the auto-refill threshold.
// - Side value applied on every stalled cycle too.
// - Output shift with both empty stalls, loads, then shifts with refill.
// - Refill between shifts when counter at threshold and queue non-empty.
// - Never load empty register and shift it in one cycle.
// - With auto-refill, explicit refill is no-op when full, else refills, stalling while transmit queue empty.
module scaf_core (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // Wishbone slave
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [3:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic      [31:0]        dat_o,
   output logic                    ack_o,
   // Machine side
   input  wire scaf_pkg::scaf_instr_t instr_i,
   input  wire logic               in_bit_data_valid_i,
   output scaf_pkg::scaf_resp_t    resp_o,
   output logic [4:0]              side_o,
   output logic [31:0]             isr_o,
   output scaf_pkg::scaf_flags_t   queue_level_flags_o
);
   localparam int QD = 2 * `SCAF_HALF_DEPTH;

   logic [31:0]  ctrl_q;
   logic [31:0]  mem_q [QD];
   logic [2:0]   tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [3:0]   tx_n_q, rx_n_q;
   logic [31:0]  osr_q, isr_q;
   logic [5:0]   osr_cnt_q, isr_cnt_q;
   logic [31:0]  rx_head;
   logic [31:0]  tx_head;

   wire merge_toward_receive  = ctrl_q[`SCAF_CTRL_MRX];
   wire merge_toward_transmit = ctrl_q[`SCAF_CTRL_MTX];
   wire autopull = ctrl_q[`SCAF_CTRL_AUTOPULL];
   wire autopush = ctrl_q[`SCAF_CTRL_AUTOPUSH];

   // Threshold field decode, zero encodes 32
   function automatic logic [5:0] thresh(input logic [4:0] f);
      return (f == 5'h00) ? `SCAF_FULL_COUNT : {1'b0, f};
   endfunction

   // Saturating add
   function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
      logic [6:0] s;
      s = {1'b0, a} + {1'b0, b};
      return (s > 7'h20) ? `SCAF_FULL_COUNT : s[5:0];
   endfunction

   wire [5:0] refill_threshold = thresh(ctrl_q[`SCAF_CTRL_PULLTH +: 5]);
   wire [5:0] flush_threshold  = thresh(ctrl_q[`SCAF_CTRL_PUSHTH +: 5]);

   // Effective capacity per direction
   logic [3:0] tx_cap, rx_cap;
   always_comb begin
      tx_cap = 4'h4;
      rx_cap = 4'h4;
      if (merge_toward_receive && merge_toward_transmit) begin
         tx_cap = 4'h0;
         rx_cap = 4'h0;
      end else if (merge_toward_transmit) begin
         tx_cap = 4'h8;
         rx_cap = 4'h0;
      end else if (merge_toward_receive) begin
         tx_cap = 4'h0;
         rx_cap = 4'h8;
      end
   end

   wire tx_empty = (tx_n_q == 4'h0);
   wire tx_full  = (tx_n_q == tx_cap);
   wire rx_empty = (rx_n_q == 4'h0);
   wire rx_full  = (rx_n_q == rx_cap);
   wire [2:0] tx_mask = (tx_cap == 4'h8) ? 3'h7 : 3'h3;
   wire [2:0] rx_mask = (rx_cap == 4'h8) ? 3'h7 : 3'h3;
   // Unmerged: tx uses entries 0-3, rx entries 4-7
   wire [2:0] tx_base = 3'h0;
   wire [2:0] rx_base = (rx_cap == 4'h8) ? 3'h0 : 3'h4;

   always_comb begin
      tx_head = mem_q[(tx_base + tx_rp_q) & 3'h7];
      rx_head = mem_q[(rx_base + rx_rp_q) & 3'h7];
   end

   // Bus decode
   wire bus_req   = cyc_i && stb_i && !ack_o;
   wire bus_wr    = bus_req && we_i && (sel_i == 4'hF);
   wire ctrl_wr   = bus_wr && (adr_i == `SCAF_OFF_CTRL);
   wire tx_wr     = bus_wr && (adr_i == `SCAF_OFF_TXDATA) && !tx_full;
   wire rx_rd     = bus_req && !we_i && (adr_i == `SCAF_OFF_RXDATA) && !rx_empty;
   wire merge_chg = ctrl_wr && (dat_i[`SCAF_CTRL_MTX:`SCAF_CTRL_MRX] !=
                                ctrl_q[`SCAF_CTRL_MTX:`SCAF_CTRL_MRX]);
   wire restart   = ctrl_wr && dat_i[`SCAF_CTRL_RESTART];

   // Machine-side decisions
   scaf_pkg::scaf_op_t op;
   logic tx_pop, rx_push, stall;
   logic [31:0] push_word;
   logic [31:0] isr_next;
   logic [5:0]  isr_cnt_next;
   always_comb begin
      op           = instr_i.op;
      tx_pop       = 1'b0;
      rx_push      = 1'b0;
      stall        = 1'b0;
      push_word    = isr_q;
      isr_next     = isr_q;
      isr_cnt_next = isr_cnt_q;
      unique case (op)
         scaf_pkg::SCAF_OP_OUT: begin
            if (autopull && osr_cnt_q >= refill_threshold) begin
               stall  = 1'b1;
               tx_pop = !tx_empty;
            end else if (autopull && sat_add(osr_cnt_q, instr_i.count) >= refill_threshold) begin
               tx_pop = !tx_empty;
            end
         end
         scaf_pkg::SCAF_OP_IN: begin
            isr_next     = (instr_i.count == 6'h20) ? instr_i.data
                           : ((isr_q << instr_i.count[4:0]) | (instr_i.data & ~(32'hFFFF_FFFF << instr_i.count[4:0])));
            isr_cnt_next = sat_add(isr_cnt_q, instr_i.count);
            if (autopush && isr_cnt_next >= flush_threshold) begin
               if (rx_full) begin
                  stall = 1'b1;
               end else begin
                  rx_push   = 1'b1;
                  push_word = isr_next;
               end
            end
         end
         scaf_pkg::SCAF_OP_PULL: begin
            if (autopull && osr_cnt_q < refill_threshold) begin
               stall = 1'b0;
            end else if (instr_i.if_flag && osr_cnt_q < refill_threshold) begin
               stall = 1'b0;
            end else begin
               tx_pop = !tx_empty;
               stall  = tx_empty;
            end
         end
         scaf_pkg::SCAF_OP_PUSH: begin
            rx_push = !rx_full;
            stall   = rx_full;
         end
         default: begin
            if (autopull && osr_cnt_q >= refill_threshold && !tx_empty && op != scaf_pkg::SCAF_OP_MOV_OSR) begin
               tx_pop = 1'b1;
            end
         end
      endcase
   end

   wire out_go = (op == scaf_pkg::SCAF_OP_OUT) && !stall;

   // Queue storage
   always_ff @(posedge clk_i) begin
      if (tx_wr) begin
         mem_q[(tx_base + tx_wp_q) & 3'h7] <= dat_i;
      end
      if (rx_push) begin
         mem_q[(rx_base + rx_wp_q) & 3'h7] <= push_word;
      end
   end

   // Queue pointers and levels
   always_ff @(posedge clk_i) begin
      if (rst_i || merge_chg) begin
         tx_wp_q <= 3'h0;
         tx_rp_q <= 3'h0;
         rx_wp_q <= 3'h0;
         rx_rp_q <= 3'h0;
         tx_n_q  <= 4'h0;
         rx_n_q  <= 4'h0;
      end else begin
         if (tx_wr) tx_wp_q <= (tx_wp_q + 3'h1) & tx_mask;
         if (tx_pop) tx_rp_q <= (tx_rp_q + 3'h1) & tx_mask;
         if (rx_push) rx_wp_q <= (rx_wp_q + 3'h1) & rx_mask;
         if (rx_rd) rx_rp_q <= (rx_rp_q + 3'h1) & rx_mask;
         tx_n_q <= tx_n_q + {3'h0, tx_wr} - {3'h0, tx_pop};
         rx_n_q <= rx_n_q + {3'h0, rx_push} - {3'h0, rx_rd};
      end
   end

   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= `SCAF_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= {1'b0, dat_i[30:0]};
      end
   end

   // Output shift register and counter
   always_ff @(posedge clk_i) begin
      if (rst_i || restart) begin
         osr_q     <= 32'h0000_0000;
         osr_cnt_q <= `SCAF_OSR_RESET;
      end else if (tx_pop) begin
         osr_q     <= tx_head;
         osr_cnt_q <= 6'h00;
      end else if (op == scaf_pkg::SCAF_OP_MOV_OSR) begin
         osr_q     <= instr_i.data;
         osr_cnt_q <= 6'h00;
      end else if (out_go) begin
         osr_q     <= (instr_i.count == 6'h20) ? 32'h0000_0000 : (osr_q >> instr_i.count[4:0]);
         osr_cnt_q <= sat_add(osr_cnt_q, instr_i.count);
      end
   end

   // Input shift register and counter
   always_ff @(posedge clk_i) begin
      if (rst_i || restart) begin
         isr_q     <= 32'h0000_0000;
         isr_cnt_q <= `SCAF_ISR_RESET;
      end else if (rx_push) begin
         isr_q     <= 32'h0000_0000;
         isr_cnt_q <= 6'h00;
      end else if (op == scaf_pkg::SCAF_OP_IN && in_bit_data_valid_i) begin
         isr_q     <= isr_next;
         isr_cnt_q <= isr_cnt_next;
      end else if (op == scaf_pkg::SCAF_OP_MOV_ISR) begin
         isr_q     <= instr_i.data;
         isr_cnt_q <= 6'h00;
      end else if (op == scaf_pkg::SCAF_OP_OUT_ISR && !stall) begin
         isr_q     <= instr_i.data;
         isr_cnt_q <= instr_i.count;
      end
   end

   // Machine outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resp_o              <= '0;
         side_o              <= 5'h00;
         isr_o               <= 32'h0000_0000;
         queue_level_flags_o <= '0;
      end else begin
         resp_o.stall      <= stall;
         resp_o.out_valid  <= out_go;
         resp_o.out_data   <= osr_q;
         resp_o.push_valid <= rx_push;
         if (instr_i.side_valid) side_o <= instr_i.side_value;
         isr_o             <= isr_q;
         queue_level_flags_o <= '{rx_full, rx_empty, tx_full, tx_empty};
      end
   end

   // Bus answer, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         if (bus_req && !we_i) begin
            unique case (adr_i)
               `SCAF_OFF_CTRL:   dat_o <= ctrl_q;
               `SCAF_OFF_RXDATA: dat_o <= rx_empty ? 32'h0000_0000 : rx_head;
               `SCAF_OFF_STATUS: dat_o <= {20'h0, isr_cnt_q[3:0] & 4'h0, 2'h0, osr_cnt_q[5:4] & 2'h0,
                                           rx_full, rx_empty, tx_full, tx_empty};
               default:          dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   a_restart_counts: assert property (@(posedge clk_i) disable iff (rst_i)
      restart |=> (osr_cnt_q == 6'h20 && isr_cnt_q == 6'h00)) else $error("restart counts wrong");
   a_counter_sat: assert property (@(posedge clk_i) disable iff (rst_i)
      osr_cnt_q <= 6'h20 && isr_cnt_q <= 6'h20) else $error("counter above 32");
   a_merge_tx_flags: assert property (@(posedge clk_i) disable iff (rst_i)
      (merge_toward_receive && !merge_chg) |=> (queue_level_flags_o.tx_full && queue_level_flags_o.tx_empty))
      else $error("tx flags wrong when merged to rx");
   a_push_stall_rx: assert property (@(posedge clk_i) disable iff (rst_i)
      (merge_toward_transmit && op == scaf_pkg::SCAF_OP_PUSH) |-> stall) else $error("push not stalled");
   a_merge_flush: assert property (@(posedge clk_i) disable iff (rst_i)
      merge_chg |=> (tx_n_q == 4'h0 && rx_n_q == 4'h0)) else $error("queues not discarded");
   a_refill_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      (tx_pop && !restart) |=> osr_cnt_q == 6'h00) else $error("refill did not zero");
   a_no_load_shift: assert property (@(posedge clk_i) disable iff (rst_i)
      (op == scaf_pkg::SCAF_OP_OUT && autopull && osr_cnt_q >= refill_threshold) |-> !out_go)
      else $error("shift of empty register");
   a_flush_full: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_push) |-> !rx_full) else $error("push into full queue");
   a_depth_cap: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_n_q <= tx_cap && rx_n_q <= rx_cap) else $error("level over capacity");
endmodule

// ===== scaf_wb_master.sv
`timescale 1ns/10ps
module scaf_wb_master (
   // Clock
   input  wire logic        clk_i,
   // Slave answer
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   // Request
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [3:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 4'h0;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // Released lines show the inverse of the last value
   task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      // Ack sampled at the rising edge; request held until then
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o  <= ~w;
      adr_o <= ~a;
      sel_o <= 4'h0;
      dat_o <= ~d;
   endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
   logic                  clk_i;
   logic                  rst_i;
   logic                  cyc_i;
   logic                  stb_i;
   logic                  we_i;
   logic [3:0]            adr_i;
   logic [3:0]            sel_i;
   logic [31:0]           dat_i;
   logic [31:0]           dat_o;
   logic                  ack_o;
   scaf_pkg::scaf_instr_t instr_i;
   logic                  in_bit_data_valid_i;
   scaf_pkg::scaf_resp_t  resp_o;
   logic [4:0]            side_o;
   logic [31:0]           isr_o;
   scaf_pkg::scaf_flags_t queue_level_flags_o;
   scaf_pkg::scaf_resp_t  r;
   int                    fail_count;
   int                    checks_done;
   int                    mode;
   int                    modes[4] = '{0, 8, 4, 12};
   integer                seed;
   logic [31:0]           q;
   logic [31:0]           w;
   logic [4:0]            sv;
   logic [31:0]           txq[$];

   scaf_core uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .instr_i(instr_i),
      .in_bit_data_valid_i(in_bit_data_valid_i), .resp_o(resp_o), .side_o(side_o),
      .isr_o(isr_o), .queue_level_flags_o(queue_level_flags_o));

   scaf_wb_master bus (
      .clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
      .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));

   function automatic int tdep();
      return mode[2] ? 0 : (mode[3] ? 8 : 4);
   endfunction

   // Receive side is always drained in the model
   function automatic logic [31:0] stat(input int tn);
      int dr;
      dr = mode[3] ? 0 : (mode[2] ? 8 : 4);
      return {28'h0, dr == 0, 1'b1, tn == tdep(), tn == 0};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic ctrl(input int m);
      mode = m;
      txq.delete();
      bus.xfer(1'b1, 4'h0, 32'(m), q);
   endtask

   task automatic txw(input logic [31:0] d);
      bus.xfer(1'b1, 4'h4, d, q);
      if (txq.size() < tdep())
         txq.push_back(d);
   endtask

   task automatic status();
      bus.xfer(1'b0, 4'hC, 32'h0, q);
      chk("status", q, stat(txq.size()));
      chk("flags", 32'(queue_level_flags_o), stat(txq.size()));
   endtask

   // One instruction, retried while the answer says stall
   task automatic exec(input scaf_pkg::scaf_op_t op, input logic [31:0] d, input int tries);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         sv = 5'($random(seed));
         instr_i.op <= op;
         instr_i.data <= d;
         instr_i.side_value <= sv;
         @(posedge clk_i);
         instr_i.op <= scaf_pkg::SCAF_OP_NONE;
         #1;
         r = resp_o;
         chk("side", 32'(side_o), 32'(sv));
         n++;
      end while (r.stall === 1'b1 && n < tries);
   endtask

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   initial begin
      #500000;
      fail_count++;
      test_done();
   end

   initial begin
      seed = 32'hcaf6;
      fail_count = 0;
      checks_done = 0;
      mode = 0;
      rst_i = 1'b1;
      instr_i = '0;
      instr_i.count = 6'h20;
      instr_i.side_valid = 1'b1;
      in_bit_data_valid_i = 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      status();
      bus.xfer(1'b0, 4'h1, 32'h0, q);
      chk("unmapped", q, 32'h0);
      foreach (modes[i]) begin
         ctrl(modes[i]);
         status();
         repeat (9) txw($random(seed));
         status();
      end
      // Auto refill and flush, both thresholds coded as zero
      ctrl(3);
      repeat (3) begin
         w = $random(seed);
         txw(w);
         exec(scaf_pkg::SCAF_OP_OUT, 32'h0, 1);
         chk("out", r.out_data, txq.pop_front());
         exec(scaf_pkg::SCAF_OP_IN, w, 1);
         chk("push", 32'(r.push_valid), 32'h1);
         bus.xfer(1'b0, 4'h8, 32'h0, q);
         chk("rx", q, w);
      end
      status();
      // Eight deep transmit queue drained by shifts
      ctrl(9);
      exec(scaf_pkg::SCAF_OP_OUT, 32'h0, 1);
      chk("stall", 32'(r.stall), 32'h1);
      repeat (8) txw($random(seed));
      repeat (8) begin
         exec(scaf_pkg::SCAF_OP_OUT, 32'h0, 1);
         chk("out", r.out_data, txq.pop_front());
         chk("out valid", 32'(r.out_valid), 32'h1);
      end
      exec(scaf_pkg::SCAF_OP_MOV_ISR, 32'hA5A5_0F0F, 1);
      @(posedge clk_i);
      #1;
      chk("isr", isr_o, 32'hA5A5_0F0F);
      status();
      exec(scaf_pkg::SCAF_OP_PUSH, 32'h0, 1);
      chk("push stall", 32'(r.stall), 32'h1);
      test_done();
   end
endmodule
